// [logic/seg_mmu_defines.svh]
`ifndef SEG_MMU_DEFINES_SVH
`define SEG_MMU_DEFINES_SVH
// command codes
`define CMD_MODE        8'h00
`define CMD_SEG_PTR     8'h01
`define CMD_RD_VKIND    8'h02
`define CMD_RD_VSEG     8'h03
`define CMD_RD_VOFF     8'h04
`define CMD_RD_BSTAT    8'h05
`define CMD_RD_ISEG     8'h06
`define CMD_RD_IOFF     8'h07
`define CMD_BASE        8'h08
`define CMD_DESC_ALL    8'h0b
`define CMD_BASE_INC    8'h0c
`define CMD_DESC_INC    8'h0f
`define CMD_CLR_VKIND   8'h11
`define CMD_CLR_SWW     8'h13
`define CMD_CLR_FATAL_ERROR_FLAG    8'h14
`define CMD_SET_CPUINH  8'h15
`define CMD_SET_DMAINH  8'h16
`define CMD_SEL_CNT     8'h20
// status codes
`define ST_REFRESH      4'h1
`define ST_IO           4'h2
`define ST_SPECIAL_IO   4'h3
`define ST_TRAP_ACK     4'h4
`define ST_DATA_MEM     4'h8
`define ST_STACK_MEM    4'h9
`define ST_IFETCH_FIRST 4'hd
// mode register fields
`define MODE_ENABLE_BIT 7
`define MODE_ID_LSB     0
`define MODE_ID_W       3
// attribute bits
`define ATTR_RDONLY     0
`define ATTR_SYSONLY    1
`define ATTR_CPUINH     2
`define ATTR_EXECONLY   3
`define ATTR_DMAINH     4
`define ATTR_DIRECTION_WARNING_ATTRIBUTE       5
// violation kind bits
`define VK_ACCESS       0
`define VK_SWW          5
`define VK_FATAL_ERROR_FLAG         6
// dma return timing and ack line base
`define DMA_SYNC_CYCLES 2
`define ACK_LINE_BASE   8
`endif

// [logic/seg_mmu_pkg.sv]
package seg_mmu_pkg;
  typedef enum logic [1:0] {
    cyc_idle,
    cyc_mem,
    cyc_cmd,
    cyc_ack
  } cycle_kind_t;
endpackage : seg_mmu_pkg

// [logic/segment_mmu_command_trap.sv]
`timescale 1ns/1ps
`default_nettype none
`include "seg_mmu_defines.svh"
// Contract
// - descriptor field commands, 0c-0f advance pointer
// - commands 15/16 set all inhibit flags
// - mode, pointer, selection counter by command
// - status registers readable by codes 02-07
// - status read-only; 11/13/14 clear flags
// - latch offset at strobe rise, drive address
// - fault: trap and suppress, trap until ack
// - cpu violation suppresses until instruction end
// - dma violation suppresses once, no trap
// - command cycle: status 0011, select, data
// - io and refresh: no translation, float
// - reset clears mode, kind, counter; enable
// - float after reset; disabled ignores addresses
// - clear kind command also ends cpu suppression
// - trap on violation or direction warning write
// - keep handling violations while trap pending
// - acknowledge drives line chosen by id
// - ack line 8+i, 1 if requested
// - sync low means dma, ignore segment
// - two sync-high cycles return to cpu
// - six lines index, seventh enables unit
// - decode four-bit status code
// - no second warning trap while warning flag set
module segment_mmu_command_trap #(
  parameter int NSEG = 64
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // cpu bus pins (asynchronous, synchronised inside)
  input  wire logic       as_n,
  input  wire logic       ds_n,
  input  wire logic       rd_wr_n,
  input  wire logic       unit_select_n,
  input  wire logic [3:0] cpu_status_code_lines,
  input  wire logic [6:0] segment_number_lines,
  input  wire logic       dma_segment_sync_input,
  input  wire logic       instr_end,
  // multiplexed address/data
  input  wire logic [7:0] upper_address_data_lines_in,
  output logic      [7:0] upper_address_data_lines_out,
  output logic      [7:0] upper_address_data_lines_oe,
  // translated address
  output logic     [15:0] physical_address_outputs,
  output logic            physical_address_oe,
  // open-drain outputs, oe high pulls low
  output logic            trap_request_output_oe,
  output logic            suppress_output_oe
);
  import seg_mmu_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // input synchronisers: first stage read only by second
  // 25 pin bits in all: strobes, select, status, segment, sync, end, a/d
  logic [24:0] sync1_reg;                 // first stage
  logic [24:0] sync2_reg;                 // usable stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= 25'h1ffffff;
      sync2_reg <= 25'h1ffffff;
    end else begin
      sync1_reg <= {as_n, ds_n, rd_wr_n, unit_select_n, cpu_status_code_lines,
                    segment_number_lines, dma_segment_sync_input, instr_end,
                    upper_address_data_lines_in};
      sync2_reg <= sync1_reg;
    end
  end
  logic       as_s, ds_s, rw_s, sel_s, sync_s, iend_s;
  logic [3:0] st_s;                       // status code
  logic [6:0] sn_s;                       // segment number
  logic [7:0] ad_s;                       // upper a/d lines
  assign {as_s, ds_s, rw_s, sel_s, st_s, sn_s, sync_s, iend_s, ad_s} = sync2_reg;

  //////////////////////////////////////////////////////////////////////////////
  // strobe edge detection on synchronised copies
  logic as_q_reg, ds_q_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      as_q_reg <= 1'b1;
      ds_q_reg <= 1'b1;
    end else begin
      as_q_reg <= as_s;
      ds_q_reg <= ds_s;
    end
  end
  logic as_rise, ds_fall, ds_rise;
  assign as_rise = as_s && !as_q_reg;
  assign ds_fall = !ds_s && ds_q_reg;
  assign ds_rise = ds_s && !ds_q_reg;

  //////////////////////////////////////////////////////////////////////////////
  // dma tracking: sync low means dma; two high cycles return cpu
  logic [1:0] sync_hi_cnt_reg;
  logic       dma_mode_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_hi_cnt_reg <= 2'h0;
      dma_mode_reg    <= 1'b0;
    end else if (!sync_s) begin
      sync_hi_cnt_reg <= 2'h0;
      dma_mode_reg    <= 1'b1;
    end else if (dma_mode_reg) begin
      if (sync_hi_cnt_reg == 2'(`DMA_SYNC_CYCLES - 1))
        dma_mode_reg <= 1'b0;
      sync_hi_cnt_reg <= sync_hi_cnt_reg + 2'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // cycle capture at address strobe rise
  cycle_kind_t kind_reg;
  logic [7:0]  cmd_reg;                   // latched command / offset byte
  logic [6:0]  seg_reg;                   // segment latched a clock early
  logic [6:0]  seg_early_reg;
  logic        cyc_dma_reg, cyc_wr_reg, cyc_sys_reg;
  logic        seg_ok_reg;                // segment usable for the check
  logic [3:0]  cyc_st_reg;
  logic        mode_en;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) seg_early_reg <= 7'h00;
    else if (sync_s) seg_early_reg <= sn_s;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      kind_reg <= cyc_idle; cmd_reg <= 8'h00; seg_reg <= 7'h00;
      cyc_dma_reg <= 1'b0; cyc_wr_reg <= 1'b0; cyc_sys_reg <= 1'b0;
      cyc_st_reg <= 4'h0;
      seg_ok_reg <= 1'b0;
    end else if (as_rise) begin
      cmd_reg     <= ad_s;
      seg_reg     <= seg_early_reg;
      seg_ok_reg  <= !dma_mode_reg;
      cyc_dma_reg <= dma_mode_reg;
      cyc_wr_reg  <= !rw_s;
      cyc_st_reg  <= st_s;
      cyc_sys_reg <= (st_s == `ST_STACK_MEM);
      // status decode
      if (st_s == `ST_SPECIAL_IO && !sel_s)
        kind_reg <= cyc_cmd;
      else if (st_s == `ST_TRAP_ACK)
        kind_reg <= cyc_ack;
      else if (st_s[3] && mode_en && (st_s != `ST_IO) && (st_s != `ST_REFRESH))
        kind_reg <= cyc_mem;
      else
        kind_reg <= cyc_idle;
    end else if (ds_rise) begin
      kind_reg <= cyc_idle;
    end else if (kind_reg == cyc_mem && !seg_ok_reg && sync_s) begin
      // dma segment lines only count once sync is high again
      seg_reg    <= sn_s;
      seg_ok_reg <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // descriptor storage and control registers
  logic [15:0] base_reg [NSEG];
  logic [7:0]  limit_reg [NSEG];
  logic [7:0]  attr_reg [NSEG];
  logic [7:0]  mode_reg;                  // mode register
  logic [5:0]  segment_address_pointer;
  logic [1:0]  sel_cnt_reg;               // descriptor selection counter
  assign mode_en = mode_reg[`MODE_ENABLE_BIT];
  logic        wr_cmd, rd_cmd, inc_field, last_byte;
  assign wr_cmd = (kind_reg == cyc_cmd) && cyc_wr_reg && ds_rise; // data late in t2
  assign rd_cmd = (kind_reg == cyc_cmd) && !cyc_wr_reg && ds_fall;
  // base takes two bytes, whole descriptor four
  assign last_byte = (cmd_reg[1:0] == 2'h0) ? (sel_cnt_reg == 2'h1) :
                     (cmd_reg[1:0] == 2'h3) ? (sel_cnt_reg == 2'h3) : 1'b1;
  assign inc_field = (cmd_reg >= `CMD_BASE_INC) && (cmd_reg <= `CMD_DESC_INC);
  logic [1:0] field;                      // field in use for this byte
  assign field = (cmd_reg[1:0] == 2'h3) ? ((sel_cnt_reg <= 2'h1) ? 2'h0 : (sel_cnt_reg - 2'h1)) : cmd_reg[1:0];

  // mode register, id field and master enable
  // select reaches sel_s two edges after release, so look on the third
  logic [1:0] reset_seen_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_reg       <= 8'h00;
      reset_seen_reg <= 2'h3;
    end else begin
      if (reset_seen_reg != 2'h0)
        reset_seen_reg <= reset_seen_reg - 2'h1;
      if (reset_seen_reg == 2'h1 && !sel_s)
        mode_reg[`MODE_ENABLE_BIT] <= 1'b1;
      else if (wr_cmd && cmd_reg == `CMD_MODE)
        mode_reg <= ad_s;
    end
  end

  // pointer and selection counter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      segment_address_pointer <= 6'h00;
      sel_cnt_reg             <= 2'h0;
    end else if ((wr_cmd || (kind_reg == cyc_cmd && !cyc_wr_reg && ds_rise))) begin
      if (wr_cmd && cmd_reg == `CMD_SEG_PTR)
        segment_address_pointer <= ad_s[5:0];
      else if (wr_cmd && cmd_reg == `CMD_SEL_CNT)
        sel_cnt_reg <= ad_s[1:0];
      else if (cmd_reg >= `CMD_BASE && cmd_reg <= `CMD_DESC_INC) begin
        sel_cnt_reg <= last_byte ? 2'h0 : sel_cnt_reg + 2'h1;
        if (last_byte && inc_field)
          segment_address_pointer <= segment_address_pointer + 6'h01;
      end
    end
  end

  // descriptor writes and global inhibit set
  genvar gi;
  generate
    for (gi = 0; gi < NSEG; gi++) begin : g_desc
      always_ff @(posedge clk) begin
        if (wr_cmd && segment_address_pointer == 6'(gi) && cmd_reg >= `CMD_BASE && cmd_reg <= `CMD_DESC_INC) begin
          case (field)
            2'h0: if (sel_cnt_reg == 2'h0) base_reg[gi][15:8] <= ad_s;
                  else base_reg[gi][7:0] <= ad_s;
            2'h1: limit_reg[gi] <= ad_s;
            default: attr_reg[gi] <= ad_s;
          endcase
        end else if (kind_reg == cyc_cmd && ds_rise && cmd_reg == `CMD_SET_CPUINH)
          attr_reg[gi][`ATTR_CPUINH] <= 1'b1;
        else if (kind_reg == cyc_cmd && ds_rise && cmd_reg == `CMD_SET_DMAINH)
          attr_reg[gi][`ATTR_DMAINH] <= 1'b1;
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // protection check for the current memory cycle
  logic [7:0] attr_cur;
  logic       viol, warn, mem_chk;
  assign attr_cur = attr_reg[seg_reg[5:0]];
  assign mem_chk  = (kind_reg == cyc_mem) && seg_ok_reg && (seg_reg[6] == mode_reg[6]);
  assign viol = mem_chk && ((cyc_wr_reg && attr_cur[`ATTR_RDONLY]) ||
                (cyc_dma_reg ? attr_cur[`ATTR_DMAINH] : attr_cur[`ATTR_CPUINH]) ||
                (cmd_reg > limit_reg[seg_reg[5:0]]));
  assign warn = mem_chk && cyc_wr_reg && attr_cur[`ATTR_DIRECTION_WARNING_ATTRIBUTE] && (cmd_reg == 8'h00);

  //////////////////////////////////////////////////////////////////////////////
  // fault tracking, trap and suppress
  logic [7:0] violation_kind_register;
  logic [6:0] vseg_reg, iseg_reg;
  logic [7:0] voff_reg, ioff_reg;
  logic       cpu_supp_reg, checked_reg;
  logic       clr_kind;
  assign clr_kind = kind_reg == cyc_cmd && ds_rise && cmd_reg == `CMD_CLR_VKIND;
  logic chk_now;                          // one-shot check per cycle (t2)
  assign chk_now = mem_chk && !checked_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) checked_reg <= 1'b0;
    else if (as_rise) checked_reg <= 1'b0;
    else if (mem_chk) checked_reg <= 1'b1;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      violation_kind_register <= 8'h00;
      trap_request_output_oe  <= 1'b0;
      suppress_output_oe      <= 1'b0;
      cpu_supp_reg            <= 1'b0;
      vseg_reg <= 7'h00; voff_reg <= 8'h00; iseg_reg <= 7'h00; ioff_reg <= 8'h00;
    end else begin
      if (kind_reg == cyc_mem && cyc_st_reg == `ST_IFETCH_FIRST) begin
        iseg_reg <= seg_reg; ioff_reg <= cmd_reg;
      end
      if (iend_s || clr_kind) cpu_supp_reg <= 1'b0;
      if (ds_rise) suppress_output_oe <= 1'b0;
      if (kind_reg == cyc_ack && ds_rise) trap_request_output_oe <= 1'b0;
      if (clr_kind) violation_kind_register <= 8'h00;
      if (kind_reg == cyc_cmd && ds_rise && cmd_reg == `CMD_CLR_SWW)
        violation_kind_register[`VK_SWW] <= 1'b0;
      if (kind_reg == cyc_cmd && ds_rise && cmd_reg == `CMD_CLR_FATAL_ERROR_FLAG)
        violation_kind_register[`VK_FATAL_ERROR_FLAG] <= 1'b0;
      if (chk_now && (viol || (cpu_supp_reg && !cyc_dma_reg)))
        suppress_output_oe <= 1'b1;
      if (chk_now && viol) begin
        vseg_reg <= seg_reg; voff_reg <= cmd_reg;
        if (!cyc_dma_reg) begin
          cpu_supp_reg <= 1'b1;
          if (violation_kind_register[`VK_SWW] || trap_request_output_oe)
            violation_kind_register[`VK_FATAL_ERROR_FLAG] <= 1'b1;
          violation_kind_register[`VK_ACCESS] <= 1'b1;
          if (!violation_kind_register[`VK_FATAL_ERROR_FLAG])
            trap_request_output_oe <= 1'b1;
        end
      end else if (chk_now && warn && !cyc_dma_reg) begin
        if (!violation_kind_register[`VK_SWW])
          trap_request_output_oe <= 1'b1;
        violation_kind_register[`VK_SWW] <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs: translated address and a/d read-back
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      physical_address_outputs <= 16'h0000;
      physical_address_oe      <= 1'b0;
    end else begin
      physical_address_outputs <= base_reg[seg_reg[5:0]] + {8'h00, cmd_reg};
      physical_address_oe      <= mem_chk;
    end
  end
  logic [7:0] rd_data;
  always_comb begin
    rd_data = 8'h00;
    if (cmd_reg == `CMD_MODE) rd_data = mode_reg;
    else if (cmd_reg == `CMD_SEG_PTR) rd_data = {2'h0, segment_address_pointer};
    else if (cmd_reg == `CMD_SEL_CNT) rd_data = {6'h00, sel_cnt_reg};
    else if (cmd_reg == `CMD_RD_VKIND) rd_data = violation_kind_register;
    else if (cmd_reg == `CMD_RD_VSEG) rd_data = {1'b0, vseg_reg};
    else if (cmd_reg == `CMD_RD_VOFF) rd_data = voff_reg;
    else if (cmd_reg == `CMD_RD_BSTAT) rd_data = {cyc_dma_reg, cyc_sys_reg, 1'b0, cyc_wr_reg, cyc_st_reg};
    else if (cmd_reg == `CMD_RD_ISEG) rd_data = {1'b0, iseg_reg};
    else if (cmd_reg == `CMD_RD_IOFF) rd_data = ioff_reg;
    else if (cmd_reg >= `CMD_BASE && cmd_reg <= `CMD_DESC_INC) begin
      case (field)
        2'h0: rd_data = (sel_cnt_reg == 2'h0) ? base_reg[segment_address_pointer][15:8]
                                              : base_reg[segment_address_pointer][7:0];
        2'h1: rd_data = limit_reg[segment_address_pointer];
        default: rd_data = attr_reg[segment_address_pointer];
      endcase
    end
  end
  logic [2:0] my_id;
  assign my_id = mode_reg[`MODE_ID_LSB +: `MODE_ID_W];
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      upper_address_data_lines_out <= 8'h00;
      upper_address_data_lines_oe  <= 8'h00;
    end else if (rd_cmd) begin
      upper_address_data_lines_out <= rd_data;
      upper_address_data_lines_oe  <= 8'hff;
    end else if (kind_reg == cyc_ack && ds_fall && mode_en) begin
      upper_address_data_lines_out <= 8'(trap_request_output_oe) << my_id;
      upper_address_data_lines_oe  <= 8'h01 << my_id;
    end else if (ds_rise) begin
      upper_address_data_lines_oe  <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  a_dma_no_trap: assert property (@(posedge clk) disable iff (!reset_n)
    (chk_now && cyc_dma_reg && !trap_request_output_oe) |=> !trap_request_output_oe)
    else $error("dma cycle raised trap");
  a_viol_suppress: assert property (@(posedge clk) disable iff (!reset_n)
    (chk_now && viol && !ds_rise) |=> suppress_output_oe)
    else $error("violation without suppress");
  a_io_float: assert property (@(posedge clk) disable iff (!reset_n)
    (kind_reg != cyc_mem) |=> !physical_address_oe)
    else $error("address driven outside memory cycle");
  a_sww_no_retrap: assert property (@(posedge clk) disable iff (!reset_n)
    (chk_now && warn && !viol && violation_kind_register[`VK_SWW] && !trap_request_output_oe
     && !(kind_reg == cyc_ack)) |=> !trap_request_output_oe)
    else $error("second trap with warning flag set");
  a_clear_kind: assert property (@(posedge clk) disable iff (!reset_n)
    (clr_kind && !chk_now) |=> violation_kind_register == 8'h00)
    else $error("clear kind failed");
  a_trap_holds: assert property (@(posedge clk) disable iff (!reset_n)
    (trap_request_output_oe && kind_reg != cyc_ack) |=> trap_request_output_oe)
    else $error("trap dropped without ack");
  a_dma_return: assert property (@(posedge clk) disable iff (!reset_n)
    (dma_mode_reg && sync_s) ##1 sync_s |=> !dma_mode_reg)
    else $error("dma mode held too long");
  a_ack_line: assert property (@(posedge clk) disable iff (!reset_n)
    (kind_reg == cyc_ack && ds_fall && mode_en && !rd_cmd) |=> upper_address_data_lines_oe == (8'h01 << my_id))
    else $error("wrong ack line");
  c_cpu_trap: cover property (@(posedge clk) disable iff (!reset_n) $rose(trap_request_output_oe));
  c_dma_supp: cover property (@(posedge clk) disable iff (!reset_n) chk_now && viol && cyc_dma_reg);
  c_cmd_read: cover property (@(posedge clk) disable iff (!reset_n) rd_cmd);
endmodule : segment_mmu_command_trap
`default_nettype wire

// [dv/bus_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
// behavioural cpu/dma master that runs one bus cycle at a time
module bus_master_model (
  // clock
  input  wire logic       clk,
  // strobes and qualifiers
  output logic            as_n,
  output logic            ds_n,
  output logic            rd_wr_n,
  output logic            unit_select_n,
  output logic      [3:0] status,
  output logic      [6:0] seg_num,
  output logic            seg_sync,
  // address/data
  output logic      [7:0] ad,
  input  wire logic [7:0] ad_out,
  input  wire logic [7:0] ad_oe
);
  // select held low through reset so the unit comes up enabled
  initial begin
    as_n = 1'b1;
    ds_n = 1'b1;
    rd_wr_n = 1'b1;
    unit_select_n = 1'b0;
    status = 4'h0;
    seg_num = 7'h00;
    seg_sync = 1'b1;
    ad = 8'h00;
  end
  ////////////////////////////////////////////////////////////////
  // one cycle: rw low writes d; q/qe are what the unit drives before ds rises
  task automatic cyc(input logic [3:0] s, input logic [6:0] seg, input logic rw, input logic dma,
                     input logic [7:0] a, input logic [7:0] d, output logic [7:0] q, output logic [7:0] qe);
    @(posedge clk);
    status <= s;
    rd_wr_n <= rw;
    seg_num <= dma ? ~seg : seg;
    seg_sync <= !dma;
    unit_select_n <= (s != 4'h3);
    @(posedge clk);
    as_n <= 1'b0;
    ad <= a;
    repeat (4) @(posedge clk);
    as_n <= 1'b1;
    repeat (2) @(posedge clk);
    seg_num <= seg;
    seg_sync <= 1'b1;
    repeat (2) @(posedge clk);
    ds_n <= 1'b0;
    ad <= rw ? ~a : d;
    repeat (6) @(posedge clk);
    q = ad_out;
    qe = ad_oe;
    ds_n <= 1'b1;
    repeat (6) @(posedge clk);
    // released a/d lines never keep the last value
    status <= 4'h0;
    unit_select_n <= 1'b1;
    ad <= ~ad;
  endtask : cyc
endmodule : bus_master_model
`default_nettype wire

// [dv/segment_mmu_command_trap_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// random-plus-corner bench around the whole unit
module segment_mmu_command_trap_tb_top;
  logic        clk, reset_n, instr_end, as_n, ds_n, rw_n, sel_n, sync;
  logic [3:0]  st;
  logic [6:0]  sn;
  logic [7:0]  ad, ad_out, ad_oe, q, qe, lim, off, bad, id;
  logic [15:0] pa, pa_seen, base;
  logic        pa_oe, trap_oe, sup_oe, sup_seen, trap_seen, pa_oe_seen;
  logic [5:0]  seg;
  int          err_total, n_compared, cyc_n, seed;
  // 125 mhz clock
  initial clk = 1'b0;
  always #4 clk = ~clk;
  bus_master_model BFM (.clk(clk), .as_n(as_n), .ds_n(ds_n), .rd_wr_n(rw_n), .unit_select_n(sel_n),
    .status(st), .seg_num(sn), .seg_sync(sync), .ad(ad), .ad_out(ad_out), .ad_oe(ad_oe));
  segment_mmu_command_trap DUT (.clk(clk), .reset_n(reset_n), .as_n(as_n), .ds_n(ds_n), .rd_wr_n(rw_n),
    .unit_select_n(sel_n), .cpu_status_code_lines(st), .segment_number_lines(sn),
    .dma_segment_sync_input(sync), .instr_end(instr_end), .upper_address_data_lines_in(ad),
    .upper_address_data_lines_out(ad_out), .upper_address_data_lines_oe(ad_oe),
    .physical_address_outputs(pa), .physical_address_oe(pa_oe), .trap_request_output_oe(trap_oe),
    .suppress_output_oe(sup_oe));
  ////////////////////////////////////////////////////////////////
  // sticky monitors of the outputs; timeout guards against a hung wait
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    sup_seen <= sup_seen | sup_oe;
    trap_seen <= trap_seen | trap_oe;
    pa_oe_seen <= pa_oe_seen | pa_oe;
    if (pa_oe) pa_seen <= pa;
    if (cyc_n == 5000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // command cycle; rw high reads into q
  task automatic cmd(input logic [7:0] c, input logic rw, input logic [7:0] d);
    BFM.cyc(4'h3, 7'h00, rw, 1'b0, c, d, q, qe);
  endtask : cmd
  // memory/io/ack cycle; flags cleared off the sampling edge
  task automatic mem(input logic [3:0] s, input logic rw, input logic dma, input logic [7:0] o);
    @(negedge clk);
    {sup_seen, trap_seen, pa_oe_seen} = 3'b000;
    BFM.cyc(s, {1'b0, seg}, rw, dma, o, 8'h5a, q, qe);
  endtask : mem
  task automatic done(input string name);
    $display("test %0s finished", name);
  endtask : done
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////
  initial begin
    {err_total, n_compared, cyc_n} = '0;
    {sup_seen, trap_seen, pa_oe_seen, pa_seen} = '0;
    seed = 32'h5496cf0e;
    reset_n = 1'b0;
    instr_end = 1'b0;
    id = 8'($random(seed)) & 8'h07;
    seg = 6'($random(seed));
    base = 16'($random(seed));
    lim = 8'h10 + (8'($random(seed)) & 8'h7f);
    off = 8'($random(seed)) & 8'h0f;
    bad = lim + 8'h01 + (8'($random(seed)) & 8'h3f);
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk(16'({pa_oe, trap_oe, sup_oe, ad_oe}), 16'h0);
    cmd(8'h00, 1'b1, 8'h00);
    chk(16'(q), 16'h0080);
    cmd(8'h02, 1'b1, 8'h00);
    chk(16'(q), 16'h0);
    cmd(8'h20, 1'b1, 8'h00);
    chk(16'(q), 16'h0);
    done("reset");
    // mode with random id, pointer, whole descriptor with advance
    cmd(8'h00, 1'b0, 8'h80 | id);
    cmd(8'h00, 1'b1, 8'h00);
    chk(16'(q), 16'(8'h80 | id));
    cmd(8'h01, 1'b0, 8'(seg));
    for (int i = 0; i < 4; i++)
      cmd(8'h0f, 1'b0, (i == 0) ? base[15:8] : (i == 1) ? base[7:0] : (i == 2) ? lim : 8'h00);
    cmd(8'h01, 1'b1, 8'h00);
    chk(16'(q), 16'(6'(seg + 6'h01)));
    cmd(8'h01, 1'b0, 8'(seg));
    for (int i = 0; i < 3; i++) begin
      cmd(8'h0b, 1'b1, 8'h00);
      chk(16'(q), 16'((i == 0) ? base[15:8] : (i == 1) ? base[7:0] : lim));
    end
    cmd(8'h0b, 1'b1, 8'h00);
    cmd(8'h01, 1'b1, 8'h00);
    chk(16'(q), 16'(seg));
    done("descriptor");
    // in-limit translation, then io and refresh stay untranslated
    mem(4'h8, 1'b1, 1'b0, off);
    chk(pa_seen, base + 16'(off));
    chk(16'({sup_seen, trap_seen}), 16'h0);
    for (int s = 1; s < 3; s++) begin
      mem(4'(s), 1'b1, 1'b0, off);
      chk(16'(pa_oe_seen), 16'h0);
    end
    done("translate");
    // limit violation on a stack write, then status and lingering suppress
    mem(4'h9, 1'b0, 1'b0, bad);
    chk(16'({sup_seen, trap_seen}), 16'h3);
    cmd(8'h02, 1'b0, 8'hff);
    cmd(8'h02, 1'b1, 8'h00);
    chk(16'(q), 16'h0001);
    cmd(8'h04, 1'b1, 8'h00);
    chk(16'(q), 16'(bad));
    cmd(8'h03, 1'b1, 8'h00);
    chk(16'(q), 16'(seg));
    mem(4'hd, 1'b1, 1'b0, off);
    chk(16'(sup_seen), 16'h1);
    cmd(8'h06, 1'b1, 8'h00);
    chk(16'(q), 16'(seg));
    mem(4'h4, 1'b1, 1'b0, 8'h00);
    chk(16'({qe[id[2:0]], q[id[2:0]]}), 16'h3);
    chk(16'(trap_oe), 16'h0);
    @(posedge clk) instr_end <= 1'b1;
    repeat (4) @(posedge clk);
    instr_end <= 1'b0;
    mem(4'h8, 1'b1, 1'b0, off);
    chk(16'(sup_seen), 16'h0);
    cmd(8'h11, 1'b0, 8'h00);
    cmd(8'h02, 1'b1, 8'h00);
    chk(16'(q), 16'h0);
    done("violation");
    // direction warning on a write at offset zero; a repeat with the flag set stays quiet
    cmd(8'h0a, 1'b0, 8'h20);
    mem(4'h8, 1'b0, 1'b0, 8'h00);
    chk(16'({sup_seen, trap_seen}), 16'h1);
    mem(4'h4, 1'b1, 1'b0, 8'h00);
    mem(4'h8, 1'b0, 1'b0, 8'h00);
    chk(16'({sup_seen, trap_seen}), 16'h0);
    cmd(8'h13, 1'b0, 8'h00);
    cmd(8'h02, 1'b1, 8'h00);
    chk(16'(q), 16'h0);
    done("warning");
    // dma violation: suppress only, then inhibit-all command
    mem(4'h8, 1'b1, 1'b1, bad);
    chk(16'({sup_seen, trap_seen}), 16'h2);
    repeat (4) @(posedge clk);
    cmd(8'h15, 1'b0, 8'h00);
    mem(4'h8, 1'b1, 1'b0, off);
    chk(16'(sup_seen), 16'h1);
    cmd(8'h16, 1'b0, 8'h00);
    mem(4'h8, 1'b1, 1'b1, off);
    chk(16'(sup_seen), 16'h1);
    done("inhibit");
    stop_test();
  end
endmodule : segment_mmu_command_trap_tb_top
`default_nettype wire
